// [flrb_defines.svh]
`ifndef FLRB_DEFINES_SVH
`define FLRB_DEFINES_SVH

// Address pointer values that select a configuration byte
`define FLRB_ADDR_FUSE_LOW    16'h0000
`define FLRB_ADDR_LOCK        16'h0001
`define FLRB_ADDR_FUSE_EXT    16'h0002
`define FLRB_ADDR_FUSE_HIGH   16'h0003

// Self-programming control register bit positions
`define FLRB_CTRL_EN          0
`define FLRB_CTRL_ERASE       1
`define FLRB_CTRL_WRITE       2
`define FLRB_CTRL_RDBK        3
`define FLRB_CTRL_CLRBUF      4
`define FLRB_CTRL_RWW         6

// Fuse field positions
`define FLRB_EXT_SELFPROG     0
`define FLRB_HIGH_RSTDIS      7
`define FLRB_HIGH_DBGW        6
`define FLRB_HIGH_SERPROG     5
`define FLRB_HIGH_WDT_ON      4
`define FLRB_HIGH_EEKEEP      3
`define FLRB_HIGH_BOD_MSB     2

// Windows in CPU cycles after the arming write
`define FLRB_LOAD_WINDOW      3'h3
`define FLRB_STORE_WINDOW     3'h4

// Fuse defaults: all unprogrammed except serial programming enable
`define FLRB_FUSE_LOW_RST     8'hFF
`define FLRB_FUSE_HIGH_RST    8'hDF
`define FLRB_FUSE_EXT_RST     8'hFF
`define FLRB_LOCK_RST         2'h3

`endif

// [flrb_pkg.sv]
package flrb_pkg;

    typedef enum logic [1:0] {
        FLRB_IDLE,
        FLRB_RD_ARMED,
        FLRB_ST_ARMED
    } flrb_state_e;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] ext;
        logic [1:0] lock;
    } flrb_fuses_s;

endpackage

// [flrb_fuse_store.sv]
`timescale 1ns/10ps
`include "flrb_defines.svh"

module flrb_fuse_store (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire flrb_pkg::flrb_fuses_s raw,
    output flrb_pkg::flrb_fuses_s    fuses,
    output logic                     loaded
);

    flrb_pkg::flrb_fuses_s meta_q;
    flrb_pkg::flrb_fuses_s sync_q;
    flrb_pkg::flrb_fuses_s fuses_q;
    logic [1:0]            cnt_q;
    logic                  loaded_q;

    ////////////////////////////////////////////////////////////////////////
    // The array sits outside this clock; two stages before capture
    always_ff @(posedge clk)
    begin
        meta_q <= raw;
        sync_q <= meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q    <= 2'h0;
            loaded_q <= 1'b0;
        end
        else if (!loaded_q)
        begin
            cnt_q    <= cnt_q + 2'h1;
            loaded_q <= (cnt_q == 2'h2);
        end
    end

    // Captured once after reset; no write path exists, so stores cannot alter it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fuses_q <= '{low: `FLRB_FUSE_LOW_RST, high: `FLRB_FUSE_HIGH_RST,
                         ext: `FLRB_FUSE_EXT_RST, lock: `FLRB_LOCK_RST};
        end
        else if (!loaded_q && cnt_q == 2'h2)
        begin
            fuses_q <= sync_q;
        end
    end

    assign fuses  = fuses_q;
    assign loaded = loaded_q;

    chk_fuse_read_only: assert property (
        @(posedge clk) disable iff (rst)
        loaded_q |=> $stable(fuses_q))
        else $error("fuse values changed after capture");

endmodule

// [flrb_top.sv]
`timescale 1ns/10ps
`include "flrb_defines.svh"


module flrb_top (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  CTRL_WR,
    input  wire logic [7:0]            CTRL_WDATA,
    output logic [7:0]                 CTRL_RDATA,
    input  wire logic                  EE_WRITE_BUSY,
    input  wire logic                  LOAD_REQ,
    input  wire logic [15:0]           LOAD_ADDR,
    input  wire logic [7:0]            FLASH_RDATA,
    output logic                       LOAD_VALID,
    output logic [7:0]                 LOAD_RDATA,
    input  wire logic                  STORE_REQ,
    output logic                       STORE_GO,
    output logic [2:0]                 STORE_CMD,
    input  wire flrb_pkg::flrb_fuses_s FUSE_RAW,
    output logic                       FUSES_READY,
    output logic                       WDT_FORCE_ON,
    output logic                       EE_PRESERVE,
    output logic [2:0]                 BOD_LEVEL,
    output logic                       SELF_PROG_ALLOWED,
    output logic [7:0]                 SER_FUSE_HIGH
);

    flrb_pkg::flrb_state_e state_q;
    flrb_pkg::flrb_fuses_s fuses;
    logic                  loaded;
    logic [2:0]            win_q;
    logic [2:0]            cmd_q;
    logic                  load_valid_q;
    logic [7:0]            load_rdata_q;
    logic                  store_go_q;
    logic [2:0]            store_cmd_q;
    logic [7:0]            ctrl_rdata_q;
    logic                  wdt_q;
    logic                  ee_keep_q;
    logic [2:0]            bod_q;
    logic                  selfprog_q;
    logic [7:0]            ser_high_q;
    logic                  ready_q;
    logic                  wr_ok;
    logic                  rd_arm;
    logic                  st_arm;

    ////////////////////////////////////////////////////////////////////////
    // Configuration byte lookup, used only by the load path

    function automatic logic [7:0] cfg_byte(input logic [15:0]           addr,
                                            input flrb_pkg::flrb_fuses_s f);
        logic [7:0] b;
        b = 8'hFF;
        case (addr)
            `FLRB_ADDR_FUSE_LOW:  b = f.low;
            `FLRB_ADDR_LOCK:      b = {6'h3F, f.lock};
            `FLRB_ADDR_FUSE_EXT:  b = f.ext;
            `FLRB_ADDR_FUSE_HIGH: b = f.high;
            default:              b = 8'hFF;
        endcase
        return b;
    endfunction

    flrb_fuse_store u_store (
        .clk    (CLK),
        .rst    (RST),
        .raw    (FUSE_RAW),
        .fuses  (fuses),
        .loaded (loaded)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register write decode

    // A write during an EEPROM write is dropped whole
    assign wr_ok  = CTRL_WR && !EE_WRITE_BUSY;
    assign rd_arm = wr_ok && CTRL_WDATA[`FLRB_CTRL_EN] && CTRL_WDATA[`FLRB_CTRL_RDBK];
    assign st_arm = wr_ok && CTRL_WDATA[`FLRB_CTRL_EN] && !CTRL_WDATA[`FLRB_CTRL_RDBK];

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_q <= flrb_pkg::FLRB_IDLE;
            win_q   <= 3'h0;
        end
        else if (EE_WRITE_BUSY)
        begin
            state_q <= flrb_pkg::FLRB_IDLE;
            win_q   <= 3'h0;
        end
        else if (rd_arm)
        begin
            state_q <= flrb_pkg::FLRB_RD_ARMED;
            win_q   <= `FLRB_LOAD_WINDOW;
        end
        else if (st_arm)
        begin
            state_q <= flrb_pkg::FLRB_ST_ARMED;
            win_q   <= `FLRB_STORE_WINDOW;
        end
        else if (wr_ok)
        begin
            state_q <= flrb_pkg::FLRB_IDLE;
            win_q   <= 3'h0;
        end
        else
        begin
            case (state_q)
                flrb_pkg::FLRB_RD_ARMED:
                begin
                    // Completion or timeout both drop the request
                    if (LOAD_REQ || win_q == 3'h1)
                    begin
                        state_q <= flrb_pkg::FLRB_IDLE;
                        win_q   <= 3'h0;
                    end
                    else
                    begin
                        win_q <= win_q - 3'h1;
                    end
                end
                flrb_pkg::FLRB_ST_ARMED:
                begin
                    if (STORE_REQ || win_q == 3'h1)
                    begin
                        state_q <= flrb_pkg::FLRB_IDLE;
                        win_q   <= 3'h0;
                    end
                    else
                    begin
                        win_q <= win_q - 3'h1;
                    end
                end
                flrb_pkg::FLRB_IDLE:
                begin
                    win_q <= 3'h0;
                end
                default:
                begin
                    state_q <= flrb_pkg::FLRB_IDLE;
                    win_q   <= 3'h0;
                end
            endcase
        end
    end

    // Command bits held alongside the store window
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cmd_q <= 3'h0;
        end
        else if (st_arm)
        begin
            cmd_q <= {CTRL_WDATA[`FLRB_CTRL_CLRBUF], CTRL_WDATA[`FLRB_CTRL_WRITE],
                      CTRL_WDATA[`FLRB_CTRL_ERASE]};
        end
        else if (wr_ok || EE_WRITE_BUSY || STORE_REQ || win_q == 3'h1)
        begin
            cmd_q <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register read view

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl_rdata_q <= 8'h00;
        end
        else
        begin
            ctrl_rdata_q <= 8'h00;
            ctrl_rdata_q[`FLRB_CTRL_EN]     <= (state_q != flrb_pkg::FLRB_IDLE);
            ctrl_rdata_q[`FLRB_CTRL_RDBK]   <= (state_q == flrb_pkg::FLRB_RD_ARMED);
            ctrl_rdata_q[`FLRB_CTRL_ERASE]  <= cmd_q[0];
            ctrl_rdata_q[`FLRB_CTRL_WRITE]  <= cmd_q[1];
            ctrl_rdata_q[`FLRB_CTRL_CLRBUF] <= cmd_q[2];
            // No read-while-write on this part
            ctrl_rdata_q[`FLRB_CTRL_RWW]    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program-memory load path

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            load_valid_q <= 1'b0;
            load_rdata_q <= 8'h00;
        end
        else
        begin
            load_valid_q <= LOAD_REQ;
            if (LOAD_REQ && state_q == flrb_pkg::FLRB_RD_ARMED && !EE_WRITE_BUSY && !CTRL_WR)
            begin
                // Fuse bits are returned raw: programmed reads as zero
                load_rdata_q <= cfg_byte(LOAD_ADDR, fuses);
            end
            else if (LOAD_REQ)
            begin
                load_rdata_q <= FLASH_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Store instruction gating

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            store_go_q  <= 1'b0;
            store_cmd_q <= 3'h0;
        end
        else
        begin
            // Stores in the readback window are swallowed, never reaching fuses
            store_go_q  <= STORE_REQ && state_q == flrb_pkg::FLRB_ST_ARMED
                           && !EE_WRITE_BUSY && !CTRL_WR
                           && !fuses.ext[`FLRB_EXT_SELFPROG];
            store_cmd_q <= cmd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fuse-driven controls for the rest of the chip

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wdt_q      <= 1'b0;
            ee_keep_q  <= 1'b0;
            bod_q      <= 3'h7;
            selfprog_q <= 1'b0;
            ser_high_q <= 8'hFF;
            ready_q    <= 1'b0;
        end
        else
        begin
            wdt_q      <= !fuses.high[`FLRB_HIGH_WDT_ON];
            ee_keep_q  <= !fuses.high[`FLRB_HIGH_EEKEEP];
            bod_q      <= fuses.high[`FLRB_HIGH_BOD_MSB:0];
            selfprog_q <= !fuses.ext[`FLRB_EXT_SELFPROG];
            // Serial view shows the enable as unprogrammed; it has no serial write path
            ser_high_q <= fuses.high | (8'h01 << `FLRB_HIGH_SERPROG);
            ready_q    <= loaded;
        end
    end

    assign CTRL_RDATA        = ctrl_rdata_q;
    assign LOAD_VALID        = load_valid_q;
    assign LOAD_RDATA        = load_rdata_q;
    assign STORE_GO          = store_go_q;
    assign STORE_CMD         = store_cmd_q;
    assign FUSES_READY       = ready_q;
    assign WDT_FORCE_ON      = wdt_q;
    assign EE_PRESERVE       = ee_keep_q;
    assign BOD_LEVEL         = bod_q;
    assign SELF_PROG_ALLOWED = selfprog_q;
    assign SER_FUSE_HIGH     = ser_high_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_rd_arm;
        rd_arm && !st_arm;
    endsequence

    sequence s_quiet_rd;
        (!LOAD_REQ && !CTRL_WR && !EE_WRITE_BUSY)[*2];
    endsequence

    sequence s_quiet_st;
        (!STORE_REQ && !CTRL_WR && !EE_WRITE_BUSY)[*3];
    endsequence

    sequence s_armed_load(logic [15:0] a);
        state_q == flrb_pkg::FLRB_RD_ARMED && LOAD_REQ && !CTRL_WR
        && !EE_WRITE_BUSY && LOAD_ADDR == a;
    endsequence

    chk_ee_blocks_arm: assert property (
        @(posedge CLK) disable iff (RST)
        EE_WRITE_BUSY |=> state_q == flrb_pkg::FLRB_IDLE ##1 !CTRL_RDATA[`FLRB_CTRL_EN])
        else $error("arming not blocked by EEPROM write");

    chk_rd_window_end: assert property (
        @(posedge CLK) disable iff (RST)
        s_rd_arm ##1 s_quiet_rd ##1 (!LOAD_REQ && !CTRL_WR && !EE_WRITE_BUSY)
        |=> state_q == flrb_pkg::FLRB_IDLE ##1 !CTRL_RDATA[`FLRB_CTRL_RDBK])
        else $error("readback request outlived three cycles");

    chk_st_window_end: assert property (
        @(posedge CLK) disable iff (RST)
        st_arm ##1 s_quiet_st ##1 (!STORE_REQ && !CTRL_WR && !EE_WRITE_BUSY)
        |=> state_q == flrb_pkg::FLRB_IDLE)
        else $error("store enable outlived four cycles");

    chk_lock_read: assert property (
        @(posedge CLK) disable iff (RST)
        s_armed_load(`FLRB_ADDR_LOCK)
        |=> LOAD_VALID && LOAD_RDATA[1:0] == $past(fuses.lock)
            && state_q == flrb_pkg::FLRB_IDLE)
        else $error("lock bits not returned");

    chk_low_read: assert property (
        @(posedge CLK) disable iff (RST)
        s_armed_load(`FLRB_ADDR_FUSE_LOW) |=> LOAD_RDATA == $past(fuses.low))
        else $error("fuse low byte not returned");

    chk_high_read: assert property (
        @(posedge CLK) disable iff (RST)
        s_armed_load(`FLRB_ADDR_FUSE_HIGH) |=> LOAD_RDATA == $past(fuses.high))
        else $error("fuse high byte not returned");

    chk_ext_read: assert property (
        @(posedge CLK) disable iff (RST)
        s_armed_load(`FLRB_ADDR_FUSE_EXT) |=> LOAD_RDATA[0] == $past(fuses.ext[0]))
        else $error("extended fuse byte not returned");

    chk_plain_load: assert property (
        @(posedge CLK) disable iff (RST)
        state_q == flrb_pkg::FLRB_IDLE && LOAD_REQ |=> LOAD_RDATA == $past(FLASH_RDATA))
        else $error("unarmed load did not return flash data");

    chk_rww_zero: assert property (
        @(posedge CLK) disable iff (RST)
        CTRL_RDATA[`FLRB_CTRL_RWW] == 1'b0)
        else $error("read-while-write busy read as one");

    chk_store_gate: assert property (
        @(posedge CLK) disable iff (RST)
        STORE_GO |-> !$past(fuses.ext[`FLRB_EXT_SELFPROG]) && $past(!EE_WRITE_BUSY))
        else $error("store granted while disabled");

    chk_wdt_force: assert property (
        @(posedge CLK) disable iff (RST)
        ##1 WDT_FORCE_ON == !$past(fuses.high[`FLRB_HIGH_WDT_ON]))
        else $error("watchdog force does not follow its fuse");

    chk_serial_hide: assert property (
        @(posedge CLK) disable iff (RST)
        SER_FUSE_HIGH[`FLRB_HIGH_SERPROG] == 1'b1)
        else $error("serial enable fuse visible to serial view");

endmodule

// [flrb_core_model.sv]
`timescale 1ns/10ps

module flrb_core_model (
    input  wire logic        clk,
    input  wire logic        ee_busy,
    input  wire logic        load_valid,
    input  wire logic [7:0]  load_rdata,
    input  wire logic        store_go,
    input  wire logic [2:0]  store_cmd,
    output logic             ctrl_wr,
    output logic [7:0]       ctrl_wdata,
    output logic             load_req,
    output logic [15:0]      load_addr,
    output logic [7:0]       flash_rdata,
    output logic             store_req
);

    // Flash holds a fixed pattern; outside a load the bus shows its inverse
    assign flash_rdata = (load_addr[7:0] ^ 8'h5A) ^ {8{~load_req}};

    initial
    begin
        ctrl_wr    = 1'b0;
        ctrl_wdata = 8'h00;
        load_req   = 1'b0;
        load_addr  = 16'h0000;
        store_req  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clearing honour_busy lets a scenario write during an EEPROM write on purpose
    task automatic ctrl_write(input logic [7:0] d, input logic honour_busy);
        int n;
        n = 0;
        while (honour_busy && ee_busy && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= d;
        @(posedge clk);
        ctrl_wr    <= 1'b0;
    endtask

    // Skip 0 right after a control write puts the load in the first window cycle
    task automatic load(input logic [15:0] a, input int skip, output logic v,
                        output logic [7:0] d);
        repeat (skip) @(posedge clk);
        load_req  <= 1'b1;
        load_addr <= a;
        @(posedge clk);
        load_req  <= 1'b0;
        #1;
        v = load_valid;
        d = load_rdata;
    endtask

    task automatic store(input int skip, output logic g, output logic [2:0] c);
        repeat (skip) @(posedge clk);
        store_req <= 1'b1;
        @(posedge clk);
        store_req <= 1'b0;
        #1;
        g = store_go;
        c = store_cmd;
    endtask
endmodule

// [flrb_top_test.sv]
`timescale 1ns/10ps

`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module flrb_top_test;
    logic                  clk;
    logic                  rst;
    logic                  ctrl_wr;
    logic [7:0]            ctrl_wdata;
    logic [7:0]            ctrl_rdata;
    logic                  ee_busy;
    logic                  load_req;
    logic [15:0]           load_addr;
    logic [7:0]            flash_rdata;
    logic                  load_valid;
    logic [7:0]            load_rdata;
    logic                  store_req;
    logic                  store_go;
    logic [2:0]            store_cmd;
    flrb_pkg::flrb_fuses_s fuse_raw;
    logic                  fuses_ready;
    logic                  wdt_force_on;
    logic                  ee_preserve;
    logic [2:0]            bod_level;
    logic                  self_prog_allowed;
    logic [7:0]            ser_fuse_high;
    logic                  lv;
    logic [7:0]            ld;
    logic [2:0]            sc;
    logic [7:0]            arm_tab [4];
    int                    fail_count;
    int                    checked;

    flrb_top flrb_top_inst (
        .CLK(clk), .RST(rst), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata),
        .CTRL_RDATA(ctrl_rdata), .EE_WRITE_BUSY(ee_busy), .LOAD_REQ(load_req),
        .LOAD_ADDR(load_addr), .FLASH_RDATA(flash_rdata), .LOAD_VALID(load_valid),
        .LOAD_RDATA(load_rdata), .STORE_REQ(store_req), .STORE_GO(store_go),
        .STORE_CMD(store_cmd), .FUSE_RAW(fuse_raw), .FUSES_READY(fuses_ready),
        .WDT_FORCE_ON(wdt_force_on), .EE_PRESERVE(ee_preserve), .BOD_LEVEL(bod_level),
        .SELF_PROG_ALLOWED(self_prog_allowed), .SER_FUSE_HIGH(ser_fuse_high)
    );

    flrb_core_model flrb_core_model_inst (
        .clk(clk), .ee_busy(ee_busy), .load_valid(load_valid), .load_rdata(load_rdata),
        .store_go(store_go), .store_cmd(store_cmd), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .load_req(load_req), .load_addr(load_addr),
        .flash_rdata(flash_rdata), .store_req(store_req)
    );

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] fl(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction

    task end_sim;
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Fuses must stay put from release on, since capture happens a few edges later
    task automatic do_reset(input flrb_pkg::flrb_fuses_s f);
        int n;
        n = 0;
        @(posedge clk);
        rst      <= 1'b1;
        fuse_raw <= f;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(bod_level, 3'h7)
        `CHK(ctrl_rdata, 8'h00)
        while (fuses_ready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(fuses_ready, 1'b1)
        `CHK(wdt_force_on, ~f.high[4])
        `CHK(ee_preserve, ~f.high[3])
        `CHK(bod_level, f.high[2:0])
        `CHK(self_prog_allowed, ~f.ext[0])
        `CHK(ser_fuse_high, f.high | 8'h20)
    endtask

    task automatic rb(input logic [15:0] a, input int skip, input logic [7:0] exp);
        logic       v;
        logic [7:0] d;
        flrb_core_model_inst.ctrl_write(8'h09, 1'b1);
        flrb_core_model_inst.load(a, skip, v, d);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask

    task automatic st(input logic [7:0] arm, input int skip, input logic go,
                      input logic [2:0] cmd);
        logic       g;
        logic [2:0] c;
        flrb_core_model_inst.ctrl_write(arm, 1'b1);
        flrb_core_model_inst.store(skip, g, c);
        `CHK(g, go)
        if (go)
            `CHK(c, cmd)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk        = 1'b0;
        rst        = 1'b1;
        ee_busy    = 1'b0;
        fuse_raw   = '1;
        fail_count = 0;
        checked    = 0;
        arm_tab    = '{8'h01, 8'h03, 8'h05, 8'h11};
        do_reset({8'hA5, 8'h06, 8'hFE, 2'h2});
        rb(16'h0000, 0, 8'hA5);
        rb(16'h0001, 1, 8'hFE);
        rb(16'h0002, 2, 8'hFE);
        rb(16'h0003, 0, 8'h06);
        flrb_core_model_inst.ctrl_write(8'h09, 1'b1);
        @(posedge clk);
        #1;
        `CHK(ctrl_rdata, 8'h09)
        flrb_core_model_inst.load(16'h0001, 1, lv, ld);
        `CHK(ld, 8'hFE)
        @(posedge clk);
        #1;
        `CHK(ctrl_rdata, 8'h00)
        flrb_core_model_inst.load(16'h0000, 1, lv, ld);
        `CHK(ld, fl(16'h0000))
        // Load one cycle past the window sees plain flash
        flrb_core_model_inst.ctrl_write(8'h09, 1'b1);
        flrb_core_model_inst.load(16'h0003, 3, lv, ld);
        `CHK(lv, 1'b1)
        `CHK(ld, fl(16'h0003))
        // EEPROM write both cancels an arming and drops a new control write
        flrb_core_model_inst.ctrl_write(8'h09, 1'b1);
        ee_busy <= 1'b1;
        flrb_core_model_inst.load(16'h0000, 1, lv, ld);
        `CHK(ld, fl(16'h0000))
        flrb_core_model_inst.ctrl_write(8'h09, 1'b0);
        ee_busy <= 1'b0;
        flrb_core_model_inst.load(16'h0001, 0, lv, ld);
        `CHK(ld, fl(16'h0001))
        for (int i = 0; i < 4; i++)
            st(arm_tab[i], i, 1'b1, {arm_tab[i][4], arm_tab[i][2], arm_tab[i][1]});
        // A store during an EEPROM write is never granted
        flrb_core_model_inst.ctrl_write(8'h01, 1'b1);
        ee_busy <= 1'b1;
        flrb_core_model_inst.store(0, lv, sc);
        `CHK(lv, 1'b0)
        @(posedge clk);
        ee_busy <= 1'b0;
        st(8'h01, 4, 1'b0, 3'h0);
        st(8'h09, 0, 1'b0, 3'h0);
        rb(16'h0000, 0, 8'hA5);
        // Second fuse image, taken in through a mid-run reset
        do_reset({8'h00, 8'hFF, 8'hFF, 2'h3});
        rb(16'h0000, 0, 8'h00);
        rb(16'h0001, 1, 8'hFF);
        rb(16'h0003, 2, 8'hFF);
        st(8'h01, 0, 1'b0, 3'h0);
        end_sim();
    end

    // The whole sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule
